/* pcos_pkg.sv */
// Function
// - Sensor fault drives control output at the safe failure percentage.
// - Safe value holds while fault lasts; normal control resumes after.
// - On/off mode accepts only 0 or 100 as failure percentage.
// - PID mode accepts any failure percentage from 0 to 100.
// - Loop-break timer in minutes flags an event if PV fails to react.
// - Channels assigned loop-break follow the loop-break event.
// - Loop-break interval of zero disables detection.
// - Startup shows version for 3 s, then PV/SP and outputs on.
// - Held parameter key steps through five levels every 2 s, wrapping.
// - Release enters level; short press steps on, back key steps back.
// - Password prompt precedes first parameter of the protected level.
// - Tuning indicator stays lit for the whole tuning run.
// - Output indicator follows the real state of the control output.
// - Autotune selection is off, standard or accurate.
// - Proportional band 0 to 500.0 percent; zero selects on/off.
// - Integral rate 0 to 24.00, shown only with nonzero band.
// - Derivative time 0 to 250.0 s, shown only with nonzero band.
// - PID output is time-proportioned over a 0.5 to 100.0 s cycle.
// - Hysteresis applies only in on/off mode.
// - Reverse turns on below setpoint; direct turns on above it.
// - Soft start limits output rise rate; zero disables it.
// - Four channels each pick off, control, A1, A2, A1|A2 or loop-break.
package pcos_pkg;
   localparam int CLK_NS = 8;
   localparam int TICK_MS = 100;
   localparam int TICK_CYC = TICK_MS * 1000000 / CLK_NS;
   localparam int STARTUP_MS = 3000;
   localparam int STARTUP_TICKS = STARTUP_MS / TICK_MS;
   localparam int LEVEL_MS = 2000;
   localparam int LEVEL_TICKS = LEVEL_MS / TICK_MS;
   localparam int SEC_TICKS = 1000 / TICK_MS;
   localparam int MIN_TICKS = 60000 / TICK_MS;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PB = 8'h04;
   localparam logic [7:0] A_IR = 8'h08;
   localparam logic [7:0] A_DT = 8'h0c;
   localparam logic [7:0] A_CT = 8'h10;
   localparam logic [7:0] A_HYST = 8'h14;
   localparam logic [7:0] A_SOFT = 8'h18;
   localparam logic [7:0] A_OUTSEL = 8'h1c;
   localparam logic [7:0] A_SFOUT = 8'h20;
   localparam logic [7:0] A_LBDT = 8'h24;
   localparam logic [7:0] A_STAT = 8'h28;
   localparam logic [7:0] A_VER = 8'h2c;
   localparam logic [15:0] FW_VERSION = 16'h0101; // Arbitrary value
   localparam int CTRL_TUNE_LSB = 0;
   localparam int CTRL_DIR_BIT = 2;
   localparam int CTRL_PROT_LSB = 4;
   localparam logic [15:0] PB_MAX = 16'h1388;
   localparam logic [15:0] IR_MAX = 16'h0960;
   localparam logic [15:0] DT_MAX = 16'h09c4;
   localparam logic [15:0] CT_MIN = 16'h0005;
   localparam logic [15:0] CT_MAX = 16'h03e8;
   localparam logic [6:0] PCT_FULL = 7'h64;
   localparam logic [1:0] TUNE_MAX = 2'h2;
   localparam logic [2:0] LAST_LEVEL = 3'h4;
   localparam logic [15:0] PB_RST = 16'h0000;
   localparam logic [15:0] CT_RST = 16'h0064;
   localparam logic [11:0] OUTSEL_RST = 12'h001;
   localparam logic [2:0] PROT_RST = 3'h7;
   localparam int NUM_CH = 4;
   typedef enum logic [2:0] {
      CH_OFF = 3'h0, CH_CTRL = 3'h1, CH_A1 = 3'h2,
      CH_A2 = 3'h3, CH_AOR = 3'h4, CH_LBD = 3'h5
   } pcos_chfn_t;
   typedef enum logic [1:0] {NAV_VIEW = 2'b01, NAV_HELD = 2'b10} pcos_nav_t;
   localparam logic [1:0] DISP_VERSION = 2'h0;
   localparam logic [1:0] DISP_PV = 2'h1;
   localparam logic [1:0] DISP_PARAM = 2'h2;
   typedef struct packed {
      logic [1:0] mode;
      logic [2:0] level;
      logic [3:0] param;
      logic pass_prompt;
      logic lbd_shown;
   } pcos_disp_t;
endpackage : pcos_pkg

/* pcos_plant.sv */
`timescale 1ns/1ps
`default_nettype none
module pcos_plant
#(
   parameter int TC = 4
)
(
   input wire logic clk, // Clock
   input wire logic rst_n, // Async reset
   input wire logic heat, // Actuator state
   input wire logic loop_open, // Broken actuator path
   input wire logic load, // Force a new value
   input wire logic signed [15:0] pv_in, // Forced value
   output logic signed [15:0] pv // Measured value
);
   int cnt_r;
   // Warms one unit a tick; an open loop freezes it for break tests
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= 0;
         pv <= 16'sh0000;
      end
      else if (load)
         pv <= pv_in;
      else
      begin
         cnt_r <= (cnt_r == TC - 1) ? 0 : cnt_r + 1;
         if (cnt_r == TC - 1 && heat && !loop_open)
            pv <= pv + 16'sh0001;
      end
   end
endmodule : pcos_plant
`default_nettype wire

/* pcos_top.sv */
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pcos_top
   import pcos_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   input wire logic clk, // 125 MHz
   input wire logic rst_n, // Async reset
   input wire logic [7:0] addr, // Register address
   input wire logic [15:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [15:0] rdata, // Read data, cycle after rd
   input wire logic signed [15:0] pv, // Process value
   input wire logic signed [15:0] sp, // Setpoint
   input wire logic sensor_fault_pin, // Input fault, async
   input wire logic [6:0] pid_mv, // PID result percent
   input wire logic tune_busy, // Autotune run active
   input wire logic alarm1, // Alarm 1 state
   input wire logic alarm2, // Alarm 2 state
   input wire logic key_param_pin, // Parameter key, async
   input wire logic key_back_pin, // Back key, async
   output logic [NUM_CH-1:0] out_ch, // Output channels
   output logic ind_out, // Output indicator
   output logic ind_tune, // Tuning indicator
   output logic [1:0] tune_req, // Autotune selection
   output logic [6:0] manipulated_output, // Applied output percent
   output pcos_disp_t disp // Display state
);
   logic [2:0] s1_r, s2_r;
   logic sens_fault, key_p, key_b;
   logic [23:0] tick_cnt_r;
   logic tick;
   logic [4:0] st_cnt_r;
   logic run_r;
   logic [1:0] tune_sel_r;
   logic dir_r;
   logic [2:0] prot_r;
   logic [15:0] pb_r, ir_r, dt_r, ct_r, hyst_r, soft_r;
   logic [11:0] outsel_r;
   logic [6:0] sf_pct_r;
   logic [7:0] lbd_t_r;
   logic onoff_mode;
   logic [6:0] sf_eff, pid_c, mv_nxt, mv_r;
   logic onoff_r;
   logic signed [16:0] sp_hi, sp_lo;
   logic [6:0] ss_lim_r;
   logic [19:0] ss_acc_r, ss_span;
   logic [9:0] pw_cnt_r;
   logic ctrl_r;
   logic [17:0] lbd_tmr_r;
   logic signed [15:0] snap_r;
   logic [6:0] mv_prev_r;
   logic lbd_r, lbd_restart, expect_rise, reacted;
   logic [NUM_CH-1:0] out_ch_r;
   logic ind_out_r, ind_tune_r;
   logic [15:0] rdata_r;
   pcos_nav_t nav_r;
   logic [4:0] hold_cnt_r;
   logic advanced_r, kp_prev_r, kb_prev_r, pass_r;
   logic [2:0] level_r;
   logic [3:0] param_r;

   // Async pins resynchronised; s1_r feeds only s2_r
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         s1_r <= 3'h0;
         s2_r <= 3'h0;
      end
      else
      begin
         s1_r <= {sensor_fault_pin, key_param_pin, key_back_pin};
         s2_r <= s1_r;
      end
   assign sens_fault = s2_r[2];
   assign key_p = s2_r[1];
   assign key_b = s2_r[0];

   // 100 ms time base for all long timers
   assign tick = (tick_cnt_r == 24'(TICK_CYCLES - 1));
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         tick_cnt_r <= 24'h0;
      else
         tick_cnt_r <= tick ? 24'h0 : tick_cnt_r + 24'h1;

   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         st_cnt_r <= 5'h0;
         run_r <= 1'b0;
      end
      else if (tick && !run_r)
      begin
         st_cnt_r <= st_cnt_r + 5'h1;
         if (st_cnt_r == 5'(STARTUP_TICKS - 1))
            run_r <= 1'b1;
      end

   assign onoff_mode = (pb_r == 16'h0);

   // Out-of-range writes leave the old setting in place
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         tune_sel_r <= 2'h0;
         dir_r <= 1'b0;
         prot_r <= PROT_RST;
         pb_r <= PB_RST;
         ir_r <= 16'h0;
         dt_r <= 16'h0;
         ct_r <= CT_RST;
         hyst_r <= 16'h0;
         soft_r <= 16'h0;
         outsel_r <= OUTSEL_RST;
         sf_pct_r <= 7'h0;
         lbd_t_r <= 8'h0;
      end
      else if (wr)
         case (addr)
            A_CTRL:
            begin
               if (wdata[CTRL_TUNE_LSB +: 2] <= TUNE_MAX)
                  tune_sel_r <= wdata[CTRL_TUNE_LSB +: 2];
               dir_r <= wdata[CTRL_DIR_BIT];
               prot_r <= wdata[CTRL_PROT_LSB +: 3];
            end
            A_PB: if (wdata <= PB_MAX) pb_r <= wdata;
            A_IR: if (wdata <= IR_MAX) ir_r <= wdata;
            A_DT: if (wdata <= DT_MAX) dt_r <= wdata;
            A_CT:
               if (wdata >= CT_MIN && wdata <= CT_MAX)
                  ct_r <= wdata;
            A_HYST: hyst_r <= wdata;
            A_SOFT: soft_r <= wdata;
            A_OUTSEL: outsel_r <= wdata[11:0];
            A_SFOUT:
               if (onoff_mode ? (wdata == 16'h0 || wdata == 16'(PCT_FULL))
                              : (wdata <= 16'(PCT_FULL)))
                  sf_pct_r <= wdata[6:0];
            A_LBDT: lbd_t_r <= wdata[7:0];
            default: ;
         endcase

   // PID terms read as zero while on/off mode hides them
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         rdata_r <= 16'h0;
      else if (rd)
         case (addr)
            A_CTRL: rdata_r <= {9'h0, prot_r, 1'b0, dir_r, tune_sel_r};
            A_PB: rdata_r <= pb_r;
            A_IR: rdata_r <= onoff_mode ? 16'h0 : ir_r;
            A_DT: rdata_r <= onoff_mode ? 16'h0 : dt_r;
            A_CT: rdata_r <= onoff_mode ? 16'h0 : ct_r;
            A_HYST: rdata_r <= hyst_r;
            A_SOFT: rdata_r <= soft_r;
            A_OUTSEL: rdata_r <= {4'h0, outsel_r};
            A_SFOUT: rdata_r <= {9'h0, sf_pct_r};
            A_LBDT: rdata_r <= {8'h0, lbd_t_r};
            A_STAT: rdata_r <= {out_ch_r, 4'h0, ctrl_r, sens_fault,
                                ind_tune_r, lbd_r, mv_r[3:0]};
            A_VER: rdata_r <= FW_VERSION;
            default: rdata_r <= 16'h0;
         endcase
   assign rdata = rdata_r;

   // On/off with hysteresis band above/below setpoint
   assign sp_hi = 17'(sp) + 17'(signed'({1'b0, hyst_r[14:0]}));
   assign sp_lo = 17'(sp) - 17'(signed'({1'b0, hyst_r[14:0]}));
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         onoff_r <= 1'b0;
      else if (!dir_r)
      begin
         if (pv < sp) onoff_r <= 1'b1;
         else if (17'(pv) >= sp_hi) onoff_r <= 1'b0;
      end
      else
      begin
         if (pv > sp) onoff_r <= 1'b1;
         else if (17'(pv) <= sp_lo) onoff_r <= 1'b0;
      end

   // Soft start ramp: lim rises 100 steps over soft_r seconds, or over 10 s when soft_r is below 10
   assign ss_span = 20'(soft_r * 16'(SEC_TICKS));
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         ss_lim_r <= 7'h0;
         ss_acc_r <= 20'h0;
      end
      else if (!run_r)
      begin
         ss_lim_r <= 7'h0;
         ss_acc_r <= 20'h0;
      end
      else if (soft_r == 16'h0)
         ss_lim_r <= PCT_FULL;
      else if (tick && ss_lim_r < PCT_FULL)
      begin
         if (ss_acc_r + 20'(PCT_FULL) >= ss_span)
         begin
            ss_acc_r <= ss_acc_r + 20'(PCT_FULL) - ss_span;
            ss_lim_r <= ss_lim_r + 7'h1;
         end
         else
            ss_acc_r <= ss_acc_r + 20'(PCT_FULL);
      end

   assign sf_eff = onoff_mode ? ((sf_pct_r != 7'h0) ? PCT_FULL : 7'h0)
                              : sf_pct_r;
   assign pid_c = (pid_mv > PCT_FULL) ? PCT_FULL : pid_mv;
   always_comb
   begin
      mv_nxt = onoff_mode ? (onoff_r ? PCT_FULL : 7'h0) : pid_c;
      if (mv_nxt > ss_lim_r)
         mv_nxt = ss_lim_r;
      if (sens_fault)
         mv_nxt = sf_eff;
   end
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         mv_r <= 7'h0;
      else
         mv_r <= mv_nxt;
   assign manipulated_output = mv_r;

   // Pulse period counted in 100 ms ticks, matching 0.1 s units
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         pw_cnt_r <= 10'h0;
      else if (tick)
         pw_cnt_r <= (11'(pw_cnt_r) + 11'h1 >= 11'(ct_r)) ? 10'h0
                                                          : pw_cnt_r + 10'h1;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         ctrl_r <= 1'b0;
      else if (onoff_mode)
         ctrl_r <= run_r && (mv_r == PCT_FULL);
      else
         ctrl_r <= run_r && (17'(pw_cnt_r) * 17'(PCT_FULL) <
                             17'(mv_r) * 17'(ct_r[9:0]));

   // Loop break: output held saturated, PV must move the expected way
   assign expect_rise = (mv_r == PCT_FULL) ^ dir_r;
   assign reacted = expect_rise ? (pv > snap_r) : (pv < snap_r);
   assign lbd_restart = !run_r || lbd_t_r == 8'h0 || mv_r != mv_prev_r ||
                        (mv_r != PCT_FULL && mv_r != 7'h0);
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         lbd_tmr_r <= 18'h0;
         snap_r <= 16'sh0;
         mv_prev_r <= 7'h0;
         lbd_r <= 1'b0;
      end
      else
      begin
         mv_prev_r <= mv_r;
         if (lbd_restart)
         begin
            lbd_tmr_r <= 18'h0;
            snap_r <= pv;
            if (lbd_t_r == 8'h0 || !run_r)
               lbd_r <= 1'b0;
         end
         else if (tick)
         begin
            if (lbd_tmr_r + 18'h1 >= 18'(lbd_t_r) * 18'(MIN_TICKS))
            begin
               lbd_tmr_r <= 18'h0;
               snap_r <= pv;
               lbd_r <= !reacted;
            end
            else
               lbd_tmr_r <= lbd_tmr_r + 18'h1;
         end
      end

   generate
      for (genvar i = 0; i < NUM_CH; i++)
      begin : g_ch
         always_ff @(posedge clk or negedge rst_n)
            if (!rst_n)
               out_ch_r[i] <= 1'b0;
            else if (!run_r)
               out_ch_r[i] <= 1'b0;
            else
               case (outsel_r[3*i +: 3])
                  CH_CTRL: out_ch_r[i] <= ctrl_r;
                  CH_A1: out_ch_r[i] <= alarm1;
                  CH_A2: out_ch_r[i] <= alarm2;
                  CH_AOR: out_ch_r[i] <= alarm1 | alarm2;
                  CH_LBD: out_ch_r[i] <= lbd_r;
                  default: out_ch_r[i] <= 1'b0;
               endcase
      end
   endgenerate
   assign out_ch = out_ch_r;

   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         ind_out_r <= 1'b0;
         ind_tune_r <= 1'b0;
      end
      else
      begin
         ind_out_r <= run_r & ctrl_r;
         ind_tune_r <= tune_busy;
      end
   assign ind_out = ind_out_r;
   assign ind_tune = ind_tune_r;
   assign tune_req = tune_sel_r;

   // Key navigation; keys ignored during the version screen
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         nav_r <= NAV_VIEW;
         hold_cnt_r <= 5'h0;
         advanced_r <= 1'b0;
         kp_prev_r <= 1'b0;
         kb_prev_r <= 1'b0;
         pass_r <= 1'b0;
         level_r <= 3'h0;
         param_r <= 4'h0;
      end
      else
      begin
         kp_prev_r <= key_p;
         kb_prev_r <= key_b;
         case (nav_r)
            NAV_VIEW:
               if (run_r && key_p && !kp_prev_r)
               begin
                  nav_r <= NAV_HELD;
                  hold_cnt_r <= 5'h0;
                  advanced_r <= 1'b0;
               end
               else if (run_r && key_b && !kb_prev_r && !pass_r &&
                        param_r != 4'h0)
                  param_r <= param_r - 4'h1;
            NAV_HELD:
               if (!key_p)
               begin
                  nav_r <= NAV_VIEW;
                  if (advanced_r)
                     pass_r <= (level_r == prot_r);
                  else if (pass_r)
                     pass_r <= 1'b0;
                  else if (param_r != 4'hf)
                     param_r <= param_r + 4'h1;
               end
               else if (tick)
               begin
                  if (hold_cnt_r == 5'(LEVEL_TICKS - 1))
                  begin
                     hold_cnt_r <= 5'h0;
                     advanced_r <= 1'b1;
                     level_r <= (level_r == LAST_LEVEL) ? 3'h0
                                                        : level_r + 3'h1;
                     param_r <= 4'h0;
                     pass_r <= 1'b0;
                  end
                  else
                     hold_cnt_r <= hold_cnt_r + 5'h1;
               end
            default: nav_r <= NAV_VIEW;
         endcase
      end

   always_comb
   begin
      disp.level = level_r;
      disp.param = param_r;
      disp.pass_prompt = pass_r;
      disp.lbd_shown = lbd_r;
      if (!run_r)
         disp.mode = DISP_VERSION;
      else if (level_r == 3'h0 && param_r == 4'h0 && !pass_r)
         disp.mode = DISP_PV;
      else
         disp.mode = DISP_PARAM;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sf_value_a: assert property (sens_fault |=> mv_r == $past(sf_eff))
      else $error("safe output not applied on sensor fault");
   sf_resume_a: assert property (!sens_fault && !onoff_mode &&
         ss_lim_r == PCT_FULL ##1 ss_lim_r == PCT_FULL
         |-> mv_r == $past(pid_c))
      else $error("normal control not resumed after fault");
   sf_onoff_a: assert property (wr && addr == A_SFOUT &&
         onoff_mode && wdata != 16'h0 && wdata != 16'(PCT_FULL)
         |=> $stable(sf_pct_r))
      else $error("on/off mode took illegal failure percent");
   sf_pid_a: assert property (wr && addr == A_SFOUT &&
         !onoff_mode && wdata <= 16'(PCT_FULL)
         |=> sf_pct_r == $past(wdata[6:0]))
      else $error("pid mode refused legal failure percent");
   lbd_off_a: assert property (lbd_t_r == 8'h0 |=> !lbd_r)
      else $error("loop break flagged while disabled");
   lbd_chan_a: assert property (run_r && outsel_r[5:3] == CH_LBD
         |=> out_ch_r[1] == $past(lbd_r))
      else $error("loop break channel does not follow event");
   startup_a: assert property (!run_r |-> out_ch_r == '0 &&
         disp.mode == DISP_VERSION)
      else $error("outputs active during startup");
   tune_ind_a: assert property (tune_busy [*2] |-> ind_tune)
      else $error("tuning indicator dark during tuning");
   out_ind_a: assert property (outsel_r[2:0] == CH_CTRL &&
         $stable(outsel_r) |-> out_ch_r[0] == ind_out_r)
      else $error("output indicator differs from control output");
   tune_sel_a: assert property (tune_sel_r != 2'h3)
      else $error("illegal autotune selection stored");
   pb_range_a: assert property (wr && addr == A_PB && wdata > PB_MAX
         |=> $stable(pb_r))
      else $error("proportional band out of range accepted");
   ct_range_a: assert property (ct_r >= CT_MIN && ct_r <= CT_MAX)
      else $error("cycle time out of range");
endmodule : pcos_top
`default_nettype wire

/* pcos_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pcos_top_tb;
   import pcos_pkg::*;
   localparam int TC = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic signed [15:0] pv;
   logic signed [15:0] sp = 16'sh0014;
   logic signed [15:0] pv_in = 16'sh000a;
   logic fault = 1'b0;
   logic [6:0] pid_mv = 7'h28;
   logic tune_busy = 1'b0;
   logic a1 = 1'b0;
   logic a2 = 1'b0;
   logic kp = 1'b0;
   logic kb = 1'b0;
   logic load = 1'b0;
   logic lopen = 1'b1;
   logic [NUM_CH-1:0] out_ch;
   logic ind_out;
   logic ind_tune;
   logic [1:0] tune_req;
   logic [6:0] mvo;
   pcos_disp_t disp;
   int n_fail = 0;
   int num_checks = 0;
   int n_ch;
   int n_ind;

   always #4 clk = ~clk;

   pcos_top #(.TICK_CYCLES(TC)) uut (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pv(pv), .sp(sp),
      .sensor_fault_pin(fault), .pid_mv(pid_mv), .tune_busy(tune_busy),
      .alarm1(a1), .alarm2(a2), .key_param_pin(kp), .key_back_pin(kb),
      .out_ch(out_ch), .ind_out(ind_out), .ind_tune(ind_tune),
      .tune_req(tune_req), .manipulated_output(mvo), .disp(disp));

   pcos_plant #(.TC(TC)) plant (.clk(clk), .rst_n(rst_n), .heat(ind_out),
      .loop_open(lopen), .load(load), .pv_in(pv_in), .pv(pv));

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg

   // Read data is valid from the cycle after the strobe until the next read
   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rchk

   task automatic setpv(input logic signed [15:0] v);
      @(posedge clk);
      pv_in <= v;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      cyc(8);
   endtask : setpv

   task automatic key(input logic back);
      @(posedge clk);
      if (back)
         kb <= 1'b1;
      else
         kp <= 1'b1;
      cyc(6);
      kb <= 1'b0;
      kp <= 1'b0;
      cyc(6);
   endtask : key

   initial
   begin
      #200000;
      n_fail++;
      test_done();
   end

   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rchk(A_CTRL, 16'h0070);
      rchk(A_OUTSEL, 16'h0001);
      rchk(A_CT, 16'h0000);
      rchk(A_VER, FW_VERSION);
      rchk(8'h30, 16'h0000);
      // Ramp armed during startup; 10 s span steps the limit once a tick
      wreg(A_SOFT, 16'h000a);
      cyc(70);
      chk(16'(disp.mode), 16'(DISP_VERSION));
      chk(16'(out_ch), 16'h0000);
      cyc(40);
      chk(16'(disp.mode), 16'(DISP_PV));
      cyc(100);
      chk(16'(mvo > 7'h00 && mvo < PCT_FULL), 16'h0001);
      wreg(A_PB, PB_MAX + 16'h0001);
      rchk(A_PB, 16'h0000);
      wreg(A_PB, PB_MAX);
      rchk(A_PB, PB_MAX);
      rchk(A_CT, CT_RST);
      wreg(A_CT, CT_MIN - 16'h0001);
      wreg(A_CT, CT_MAX + 16'h0001);
      rchk(A_CT, CT_RST);
      wreg(A_CT, CT_MIN);
      rchk(A_CT, CT_MIN);
      wreg(A_IR, IR_MAX + 16'h0001);
      rchk(A_IR, 16'h0000);
      wreg(A_IR, IR_MAX);
      rchk(A_IR, IR_MAX);
      wreg(A_DT, DT_MAX + 16'h0001);
      rchk(A_DT, 16'h0000);
      wreg(A_DT, DT_MAX);
      rchk(A_DT, DT_MAX);
      wreg(A_SFOUT, 16'h0065);
      wreg(A_SFOUT, 16'h0032);
      rchk(A_SFOUT, 16'h0032);
      wreg(A_CTRL, 16'h0073);
      rchk(A_CTRL, 16'h0070);
      for (int t = 0; t < 3; t++)
      begin
         wreg(A_CTRL, 16'h0070 | 16'(t));
         cyc(2);
         chk(16'(tune_req), 16'(t));
      end
      wreg(A_SOFT, 16'h0000);
      wreg(A_HYST, 16'h0002);
      // Whole periods of 20 cycles make the on count phase-free
      cyc(40);
      n_ch = 0;
      n_ind = 0;
      for (int i = 0; i < 200; i++)
      begin
         cyc(1);
         n_ch += int'(out_ch[0]);
         n_ind += int'(ind_out);
      end
      chk(16'(n_ch), 16'h0050);
      chk(16'(n_ind), 16'h0050);
      chk(16'(mvo), 16'h0028);
      @(posedge clk) fault <= 1'b1;
      cyc(6);
      chk(16'(mvo), 16'h0032);
      cyc(60);
      chk(16'(mvo), 16'h0032);
      @(posedge clk) fault <= 1'b0;
      cyc(6);
      chk(16'(mvo), 16'h0028);
      wreg(A_PB, 16'h0000);
      rchk(A_IR, 16'h0000);
      rchk(A_DT, 16'h0000);
      wreg(A_SFOUT, 16'h003c);
      rchk(A_SFOUT, 16'h0032);
      wreg(A_SFOUT, 16'h0064);
      rchk(A_SFOUT, 16'h0064);
      setpv(16'sh000a);
      chk(16'(mvo), 16'(PCT_FULL));
      chk(16'({out_ch[0], ind_out}), 16'h0003);
      setpv(16'sh0015);
      chk(16'(out_ch[0]), 16'h0001);
      setpv(16'sh0016);
      chk(16'({out_ch[0], ind_out}), 16'h0000);
      wreg(A_CTRL, 16'h0074);
      cyc(8);
      chk(16'(out_ch[0]), 16'h0001);
      setpv(16'sh0013);
      chk(16'(out_ch[0]), 16'h0001);
      setpv(16'sh0012);
      chk(16'(mvo), 16'h0000);
      wreg(A_OUTSEL, 16'h08d1);
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk);
         a1 <= k[0];
         a2 <= k[1];
         cyc(4);
         chk(16'(out_ch[3:1]), 16'({k[0] | k[1], k[1], k[0]}));
      end
      wreg(A_OUTSEL, 16'h0029);
      wreg(A_LBDT, 16'h0001);
      wreg(A_CTRL, 16'h0010);
      setpv(16'sh000a);
      cyc(2200);
      chk(16'({disp.lbd_shown, out_ch[1]}), 16'h0000);
      cyc(400);
      chk(16'({disp.lbd_shown, out_ch[1]}), 16'h0003);
      wreg(A_LBDT, 16'h0000);
      cyc(4);
      chk(16'({disp.lbd_shown, out_ch[1]}), 16'h0000);
      // Closed loop: PV climbs under full output, so no break is flagged
      sp <= 16'sh4000;
      lopen <= 1'b0;
      wreg(A_LBDT, 16'h0001);
      cyc(2600);
      chk(16'({disp.lbd_shown, out_ch[1]}), 16'h0000);
      @(posedge clk) tune_busy <= 1'b1;
      cyc(30);
      chk(16'(ind_tune), 16'h0001);
      @(posedge clk) tune_busy <= 1'b0;
      cyc(3);
      chk(16'(ind_tune), 16'h0000);
      @(posedge clk) kp <= 1'b1;
      cyc(90);
      chk(16'(disp.level), 16'h0001);
      cyc(320);
      chk(16'(disp.level), 16'h0000);
      cyc(80);
      kp <= 1'b0;
      cyc(6);
      chk(16'({disp.level, disp.pass_prompt}), 16'h0003);
      key(1'b0);
      chk(16'(disp.pass_prompt), 16'h0000);
      key(1'b0);
      chk(16'(disp.param), 16'h0001);
      key(1'b1);
      chk(16'(disp.param), 16'h0000);
      test_done();
   end
endmodule : pcos_top_tb
`default_nettype wire
